// File: hw/reset_stop_pkg.sv
// Constants for the reset and stop sequencer.
// Assumes a single 100 MHz oscillator-side clock.
`default_nettype none
package reset_stop_pkg;
    localparam int CLK_MHZ = 100;
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int PIN_MIN_US = 20;
    localparam int EXIT_CYC = 20478;
    localparam int STOP_CYC = 10239;
    localparam int CNT_W = 15;
    localparam int FLT_W = 4;
    localparam int BOOT_CYC = 16;
    localparam int BOOT_W = 5;
    localparam logic [7:0] WDOG_KEY1 = 8'hAA;
    localparam logic [7:0] WDOG_KEY2 = 8'h55;
    localparam logic [7:0] MODE_RST = 8'hE0;
    localparam logic [7:0] CENTRAL_IRQ_CONTROL_REG_RST = 8'h87;
    localparam logic [7:0] WCR_RST = 8'h7F;
    localparam logic [7:0] WDOG_TIMER_CONTROL_REG_RST = 8'h12;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam int WCR_DIS_BIT = 6;
    localparam logic [15:0] WDOG_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] RESET_VEC_ADDR = 16'h0000;
    localparam logic [1:0] DIV_RATIO = 2'h1;

    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_BOOT = 5'h02,
        ST_RUN = 5'h04,
        ST_STOP = 5'h08,
        ST_WAKE = 5'h10
    } seq_state_t;
endpackage
`default_nettype wire

// File: hw/reset_stop_sequencer.sv
// Reset and stop sequencer: reset sources, exit timing, boot, stop mode.
// Assumes all inputs synchronous to clock; supply monitor gives hysteretic level.
//
// Summary of operation
// - Enabled watchdog resets chip unless AA then 55 written within period.
// - Watchdog reset never drives the reset pin; pin stays input.
// - After reset exit, a boot sequence runs before user program.
// - Boot loads configuration and memory pointer registers.
// - After boot, program counter loads reset vector from lowest two bytes.
// - Single reset pin glitch under 50 ns does not start the exit count; core_reset follows it only while low.
// - Reset pin low over 20 us always resets.
// - After pin rises, count 20478 oscillator cycles before leaving reset.
// - Wake-up unit request stops oscillators, keeps context, no reset.
// - Internal clock held high while stopped.
// - Wake-up edge ends stop; resume after 10239 divided-clock periods.
// - Stop exit raises an interrupt and sets the stop-exit flag.
// - Supply monitor low holds static reset; thresholds give hysteresis.
// - Reset loads defined values into mode, interrupt and watchdog registers.
// - Reset puts ports into weak pull-up mode with data all ones.
// - Reset pin low starts reset immediately, no clock needed.
// - Enabled software halt is a reset source.
// - Last reset cause recorded; pin reset clears both cause flags.
// - Stop-exit flag set by hardware, cleared by software or by rst_n.
`default_nettype none
module reset_stop_sequencer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reset_pin_n,
    input wire logic supply_monitor,
    input wire logic halt_req,
    input wire logic halt_reset_en,
    input wire logic watchdog_disable_bit,
    input wire logic [15:0] wdog_period,
    input wire logic wdog_wr,
    input wire logic [7:0] wdog_wr_data,
    input wire logic stop_req,
    input wire logic wakeup_edge,
    input wire logic osc_running,
    input wire logic stop_flag_clr,
    output logic core_reset,
    output logic reset_pin_oe,
    output logic osc_enable,
    output logic core_clk_gate_high,
    output logic boot_active,
    output logic pc_load,
    output logic [15:0] pc_vector_addr,
    output logic stop_exit_irq,
    output logic stop_exit_flag,
    output logic sw_reset_flag,
    output logic wdog_reset_flag,
    output logic [7:0] core_mode_reg,
    output logic [7:0] central_irq_control_reg,
    output logic [7:0] watchdog_control_reg,
    output logic [7:0] wdog_timer_control_reg,
    output logic [7:0] port_output_data_reg,
    output logic port_weak_pullup
);
    logic sync1_q;
    logic sync2_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= 1'b1;
            sync2_q <= sync1_q;
        end
    end
    wire logic srst_n = sync2_q;

    // Pin async path: a true low pulse resets at once; the filter then decides
    // whether it was only a glitch.
    logic [reset_stop_pkg::FLT_W-1:0] flt_q;
    logic pin_low_q;
    wire logic flt_done = flt_q >= reset_stop_pkg::FLT_W'(reset_stop_pkg::GLITCH_CYC);
    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            flt_q <= '0;
            pin_low_q <= 1'b1;
        end else if (clk_en) begin
            if (reset_pin_n) begin
                flt_q <= '0;
                pin_low_q <= 1'b0;
            end else if (!flt_done) begin
                flt_q <= flt_q + 1'b1;
            end else begin
                pin_low_q <= 1'b1;
            end
        end
    end

    // Watchdog with two-byte service code
    logic [15:0] wd_cnt_q;
    logic wd_key_q;
    logic wd_fire_q;
    wire logic wd_on = !watchdog_disable_bit;
    wire logic wd_key1 = wdog_wr && (wdog_wr_data == reset_stop_pkg::WDOG_KEY1);
    wire logic wd_key2 = wdog_wr && wd_key_q && (wdog_wr_data == reset_stop_pkg::WDOG_KEY2);
    wire logic wd_expire = wd_on && (wd_cnt_q == 16'h0000);

    wire logic sw_halt = halt_req && halt_reset_en;
    wire logic any_req = pin_low_q || supply_monitor || wd_fire_q || sw_halt;

    reset_stop_pkg::seq_state_t state_q;
    logic [reset_stop_pkg::CNT_W-1:0] cnt_q;
    logic [reset_stop_pkg::BOOT_W-1:0] boot_q;
    logic div_q;
    wire logic cnt_done = cnt_q == '0;

    // One wire per state keeps the output decode flat
    wire logic in_boot = state_q == reset_stop_pkg::ST_BOOT;
    wire logic in_run = state_q == reset_stop_pkg::ST_RUN;
    wire logic in_stop = state_q == reset_stop_pkg::ST_STOP;
    wire logic in_wake = state_q == reset_stop_pkg::ST_WAKE;

    // Reload outside run so a stop or reset never leaves a stale count
    wire logic wd_reload = !in_run || wd_key2;
    wire logic wd_step = wd_on && !wd_expire;

    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            wd_cnt_q <= reset_stop_pkg::WDOG_PERIOD_RST;
            wd_key_q <= 1'b0;
            wd_fire_q <= 1'b0;
        end else if (clk_en) begin
            wd_fire_q <= wd_expire && in_run;
            if (wd_reload) begin
                wd_cnt_q <= wdog_period;
            end else if (wd_step) begin
                wd_cnt_q <= wd_cnt_q - 16'h0001;
            end
            if (wd_key1) begin
                wd_key_q <= 1'b1;
            end else if (wdog_wr) begin
                wd_key_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            state_q <= reset_stop_pkg::ST_RESET;
            cnt_q <= reset_stop_pkg::CNT_W'(reset_stop_pkg::EXIT_CYC);
            boot_q <= '0;
            div_q <= 1'b0;
        end else if (clk_en) begin
            if (any_req) begin
                state_q <= reset_stop_pkg::ST_RESET;
                cnt_q <= reset_stop_pkg::CNT_W'(reset_stop_pkg::EXIT_CYC);
                boot_q <= '0;
            end else begin
                case (state_q)
                    reset_stop_pkg::ST_RESET: begin
                        if (cnt_done) begin
                            state_q <= reset_stop_pkg::ST_BOOT;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                    reset_stop_pkg::ST_BOOT: begin
                        boot_q <= boot_q + 1'b1;
                        if (boot_q == reset_stop_pkg::BOOT_W'(reset_stop_pkg::BOOT_CYC)) begin
                            state_q <= reset_stop_pkg::ST_RUN;
                        end
                    end
                    reset_stop_pkg::ST_RUN: begin
                        if (stop_req) begin
                            state_q <= reset_stop_pkg::ST_STOP;
                        end
                    end
                    reset_stop_pkg::ST_STOP: begin
                        if (wakeup_edge) begin
                            state_q <= reset_stop_pkg::ST_WAKE;
                            cnt_q <= reset_stop_pkg::CNT_W'(reset_stop_pkg::STOP_CYC);
                            div_q <= 1'b0;
                        end
                    end
                    reset_stop_pkg::ST_WAKE: begin
                        if (osc_running) begin
                            div_q <= div_q + reset_stop_pkg::DIV_RATIO[0];
                            if (div_q) begin
                                if (cnt_done) begin
                                    state_q <= reset_stop_pkg::ST_RUN;
                                end else begin
                                    cnt_q <= cnt_q - 1'b1;
                                end
                            end
                        end
                    end
                    default: state_q <= reset_stop_pkg::ST_RESET;
                endcase
            end
        end
    end

    wire logic wake_done = (state_q == reset_stop_pkg::ST_WAKE) && !any_req && osc_running
        && div_q && cnt_done;
    wire logic boot_done = (state_q == reset_stop_pkg::ST_BOOT) && !any_req
        && (boot_q == reset_stop_pkg::BOOT_W'(reset_stop_pkg::BOOT_CYC));
    wire logic in_reset = state_q == reset_stop_pkg::ST_RESET;
    // Pin and supply resets outrank the others and leave both causes clear
    wire logic cause_hard = pin_low_q || supply_monitor;

    // Cause flags survive the reset they describe; srst or a pin or supply reset clears them
    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            sw_reset_flag <= 1'b0;
            wdog_reset_flag <= 1'b0;
            stop_exit_flag <= 1'b0;
            stop_exit_irq <= 1'b0;
            pc_load <= 1'b0;
        end else if (clk_en) begin
            if (cause_hard) begin
                sw_reset_flag <= 1'b0;
                wdog_reset_flag <= 1'b0;
            end else if (wd_fire_q) begin
                wdog_reset_flag <= 1'b1;
                sw_reset_flag <= 1'b0;
            end else if (sw_halt) begin
                sw_reset_flag <= 1'b1;
                wdog_reset_flag <= 1'b0;
            end
            if (wake_done) begin
                stop_exit_flag <= 1'b1;
            end else if (stop_flag_clr) begin
                stop_exit_flag <= 1'b0;
            end
            stop_exit_irq <= wake_done;
            pc_load <= boot_done;
        end
    end

    // Defined reset values; context kept across stop since stop never resets
    always_ff @(posedge clock or negedge srst_n) begin
        if (!srst_n) begin
            core_mode_reg <= reset_stop_pkg::MODE_RST;
            central_irq_control_reg <= reset_stop_pkg::CENTRAL_IRQ_CONTROL_REG_RST;
            watchdog_control_reg <= reset_stop_pkg::WCR_RST;
            wdog_timer_control_reg <= reset_stop_pkg::WDOG_TIMER_CONTROL_REG_RST;
            port_output_data_reg <= reset_stop_pkg::PORT_RST;
            port_weak_pullup <= 1'b1;
        end else if (clk_en && in_reset) begin
            core_mode_reg <= reset_stop_pkg::MODE_RST;
            central_irq_control_reg <= reset_stop_pkg::CENTRAL_IRQ_CONTROL_REG_RST;
            watchdog_control_reg <= reset_stop_pkg::WCR_RST;
            wdog_timer_control_reg <= reset_stop_pkg::WDOG_TIMER_CONTROL_REG_RST;
            port_output_data_reg <= reset_stop_pkg::PORT_RST;
            port_weak_pullup <= 1'b1;
        end
    end

    // Async term so a pin low resets before any clock edge
    assign core_reset = !reset_pin_n || in_reset || !srst_n;
    assign reset_pin_oe = 1'b0;
    assign osc_enable = !in_stop;
    assign core_clk_gate_high = in_stop || in_wake;
    // Boot length is fixed here; a real boot routine may take longer
    assign boot_active = in_boot;
    assign pc_vector_addr = reset_stop_pkg::RESET_VEC_ADDR;
endmodule
`default_nettype wire

// File: testbench/ext_reset_wake.sv
// External reset source, wake-up line and oscillator start-up model.
// Assumes the bench requests pin low and wake events at clock edges.
`default_nettype none
module ext_reset_wake #(parameter int START_CYC = 200) (
    input wire logic clock, pin_low, wake_go, osc_enable,
    output logic reset_pin_n, wakeup_edge, osc_running
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    assign reset_pin_n = !pin_low;
    assign wakeup_edge = wake_go;
    // Oscillator is dead while disabled and needs a start-up time
    always @(posedge clock) begin
        if (!osc_enable) cnt <= 0;
        else if (cnt < START_CYC) cnt <= cnt + 1;
    end
    assign osc_running = osc_enable && cnt >= START_CYC;
endmodule
`default_nettype wire

// File: testbench/reset_stop_monitor.sv
// Checker on the sequencer ports, attached by bind.
// Assumes one clock domain and clk_en held high by the bench.
`default_nettype none
module reset_stop_monitor (
    input wire logic clock, rst_n, reset_pin_n, supply_monitor, stop_req,
    input wire logic core_reset, reset_pin_oe, osc_enable, core_clk_gate_high,
    input wire logic boot_active, pc_load, stop_exit_irq, stop_exit_flag, wdog_reset_flag,
    input wire logic [15:0] pc_vector_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Only a full run state may accept a stop request
    sequence run_stop_s;
        stop_req && osc_enable && !core_reset && !boot_active && !core_clk_gate_high;
    endsequence
    sequence boot_run_s;
        boot_active [*8];
    endsequence
    pin_oe_a: assert property (!reset_pin_oe) else $error("reset pin driven");
    pin_async_a: assert property (!reset_pin_n |-> core_reset) else $error("pin low, no reset");
    supply_hold_a: assert property (supply_monitor |=> core_reset) else $error("supply low, no reset");
    stop_clock_a: assert property (!osc_enable |-> core_clk_gate_high) else $error("clock not high");
    stop_entry_a: assert property (run_stop_s |=> !osc_enable && !core_reset)
        else $error("stop not entered");
    boot_len_a: assert property ($rose(boot_active) |-> boot_run_s) else $error("boot cut short");
    vector_a: assert property (pc_load |-> pc_vector_addr == 16'h0000) else $error("bad vector");
    exit_irq_a: assert property (stop_exit_irq |-> stop_exit_flag) else $error("irq without flag");
    flag_src_a: assert property ($rose(stop_exit_flag) |-> stop_exit_irq) else $error("flag set alone");
    wdog_flag_a: assert property ($rose(wdog_reset_flag) |-> ##[0:2] core_reset)
        else $error("cause flag without reset");
endmodule
bind reset_stop_sequencer reset_stop_monitor i_mon (.*);
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the reset and stop sequencer.
// Assumes full-size counts from reset_stop_pkg and the ext_reset_wake partner.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_n = 1'b0, pin_low = 1'b1, wake_go = 1'b0, supply_monitor = 1'b0;
    logic halt_req = 1'b0, halt_reset_en = 1'b0, watchdog_disable_bit = 1'b1;
    logic stop_req = 1'b0, stop_flag_clr = 1'b0;
    logic [15:0] wdog_period = 16'h0010;
    logic wdog_wr = 1'b0;
    logic [7:0] wdog_wr_data = 8'h00;
    logic reset_pin_n, wakeup_edge, osc_running, core_reset, reset_pin_oe, osc_enable, pc_load;
    logic core_clk_gate_high, boot_active, stop_exit_irq, stop_exit_flag, port_weak_pullup;
    logic sw_reset_flag, wdog_reset_flag;
    logic [15:0] pc_vector_addr;
    logic [7:0] core_mode_reg, central_irq_control_reg, watchdog_control_reg;
    logic [7:0] wdog_timer_control_reg, port_output_data_reg;
    int n_fail = 0, checks_done = 0, n;

    reset_stop_sequencer i_dut (.clk_en(1'b1), .*);
    ext_reset_wake i_ext (.*);
    always #5 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return boot_active;
            1: return pc_load;
            2: return stop_exit_irq;
            default: return core_reset;
        endcase
    endfunction
    // Bounded wait, counted in cycles, sampled away from the clock edge
    task automatic wait_on(input int w, input int lim, output int cnt);
        cnt = 0;
        while (sig(w) !== 1'b1 && cnt < lim) begin
            @(negedge clock);
            cnt++;
        end
    endtask
    task automatic t_reset_exit;
        @(negedge clock);
        chk({core_mode_reg, central_irq_control_reg, watchdog_control_reg, wdog_timer_control_reg},
            {reset_stop_pkg::MODE_RST, reset_stop_pkg::CENTRAL_IRQ_CONTROL_REG_RST, reset_stop_pkg::WCR_RST,
             reset_stop_pkg::WDOG_TIMER_CONTROL_REG_RST});
        chk({port_output_data_reg, port_weak_pullup}, {reset_stop_pkg::PORT_RST, 1'b1});
        @(posedge clock) pin_low <= 1'b0;
        wait_on(0, 30000, n);
        chk(n >= reset_stop_pkg::EXIT_CYC - 1 && n <= reset_stop_pkg::EXIT_CYC + 6, 1'b1);
        wait_on(1, 40, n);
        chk(n >= reset_stop_pkg::BOOT_CYC && n <= reset_stop_pkg::BOOT_CYC + 3, 1'b1);
        chk({pc_vector_addr, sw_reset_flag, wdog_reset_flag}, 18'h0);
    endtask
    task automatic t_glitch;
        @(posedge clock) pin_low <= 1'b1;
        #2 chk(core_reset, 1'b1);
        repeat (3) @(posedge clock);
        pin_low <= 1'b0;
        repeat (20) @(negedge clock);
        chk({core_reset, boot_active}, 2'b00);
    endtask
    task automatic t_stop;
        @(posedge clock) stop_req <= 1'b1;
        @(posedge clock) stop_req <= 1'b0;
        @(negedge clock) chk({osc_enable, core_reset, core_clk_gate_high}, 3'b001);
        repeat (50) @(posedge clock);
        wake_go <= 1'b1;
        @(posedge clock) wake_go <= 1'b0;
        wait_on(2, 21000, n);
        chk(n >= 2 * reset_stop_pkg::STOP_CYC + 200
            && n <= 2 * reset_stop_pkg::STOP_CYC + 216, 1'b1);
        @(negedge clock) chk(stop_exit_flag, 1'b1);
        @(posedge clock) stop_flag_clr <= 1'b1;
        @(posedge clock) stop_flag_clr <= 1'b0;
        @(negedge clock) chk(stop_exit_flag, 1'b0);
    endtask
    // Service code on two consecutive writes, then the write strobe drops
    task automatic wd_service;
        @(posedge clock);
        wdog_wr <= 1'b1;
        wdog_wr_data <= reset_stop_pkg::WDOG_KEY1;
        @(posedge clock);
        wdog_wr_data <= reset_stop_pkg::WDOG_KEY2;
        @(posedge clock);
        wdog_wr <= 1'b0;
    endtask
    task automatic t_wdog;
        @(posedge clock) watchdog_disable_bit <= 1'b0;
        repeat (5) begin
            wd_service();
            repeat (9) @(posedge clock);
        end
        @(negedge clock) chk(core_reset, 1'b0);
        wait_on(3, 2000, n);
        chk({n < 2000, reset_pin_oe, reset_pin_n}, 3'b101);
        @(posedge clock) watchdog_disable_bit <= 1'b1;
        repeat (2) @(negedge clock);
        chk({wdog_reset_flag, sw_reset_flag}, 2'b10);
        wait_on(1, 21000, n);
    endtask
    task automatic t_halt_supply;
        @(posedge clock) halt_reset_en <= 1'b1;
        halt_req <= 1'b1;
        wait_on(3, 20, n);
        @(posedge clock) halt_req <= 1'b0;
        repeat (2) @(negedge clock);
        chk({n < 20, sw_reset_flag, wdog_reset_flag}, 3'b110);
        // Supply dip mid-count must restart the whole exit delay
        repeat (5000) @(posedge clock);
        supply_monitor <= 1'b1;
        repeat (10) @(posedge clock);
        #2 chk(core_reset, 1'b1);
        @(posedge clock) supply_monitor <= 1'b0;
        wait_on(0, 30000, n);
        chk(n >= reset_stop_pkg::EXIT_CYC - 1 && n <= reset_stop_pkg::EXIT_CYC + 8, 1'b1);
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_exit();
        t_glitch();
        t_stop();
        t_wdog();
        t_halt_supply();
        finish_test();
    end
    initial begin
        #950000;
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
